// *** rtl/gpio_pkg.sv ***
// Contract
// - Per-bit direction select for every port
// - Per-bit pull-up enable for every port
// - Reset makes every bit an input
// - Reset clears every pull-up select
// - Widths: 4, 6, 2, 2, 2, 6
// - Low reset pin holds state initialized
// - Release waits stabilization, then reset processing
// - Boot select input picks start ROM area
package gpio_pkg;
  localparam int P0_W = 4;
  localparam int P2_W = 6;
  localparam int P4_W = 2;
  localparam int P5_W = 2;
  localparam int P6_W = 2;
  localparam int P8_W = 6;
  localparam int NPORT = 6;
  localparam int ADDR_W = 6;
  // Word offsets: data, direction, pull-up for each port
  localparam logic [5:0] OFF_DATA0 = 6'h00;
  localparam logic [5:0] OFF_DIR0  = 6'h01;
  localparam logic [5:0] OFF_PLU0  = 6'h02;
  localparam logic [5:0] OFF_STEP  = 6'h03;
  localparam logic [5:0] OFF_STAT  = 6'h3c;
  localparam int STAT_BOOT_BIT  = 0;
  localparam int STAT_READY_BIT = 1;
  localparam logic [5:0] DIR_RST  = 6'h00;
  localparam logic [5:0] PLU_RST  = 6'h00;
  localparam logic [5:0] DATA_RST = 6'h00;
  localparam int CLK_HZ = 10_000_000;
  localparam int STAB_US = 100;
  localparam int STAB_CYC = (STAB_US * (CLK_HZ / 1_000_000) < 1) ? 1
                            : STAB_US * (CLK_HZ / 1_000_000);
  localparam int STAB_W = 12;
  typedef enum logic [1:0] {IN_RESET, STABILIZE, RUN} rst_state_t;
endpackage : gpio_pkg

// *** rtl/gpio_ports.sv ***
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
module gpio_ports (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Reset and boot pins
  input  wire logic        reset_in_active_low,
  input  wire logic        boot_area_select_in,
  output logic             cpu_run,
  output logic             boot_area,
  // Port pins, flat: p0[3:0] p2[9:4] p4[11:10] p5[13:12] p6[15:14] p8[21:16]
  input  wire logic [21:0] pin_in,
  output logic      [21:0] pin_out,
  output logic      [21:0] pin_oe,
  output logic      [21:0] pullup_en
);
  localparam int W [6] = '{gpio_pkg::P0_W, gpio_pkg::P2_W, gpio_pkg::P4_W,
                           gpio_pkg::P5_W, gpio_pkg::P6_W, gpio_pkg::P8_W};
  localparam int LSB [6] = '{0, 4, 10, 12, 14, 16};

  function automatic logic [5:0] width_mask(input int n);
    width_mask = 6'((1 << n) - 1);
  endfunction : width_mask

  function automatic logic [5:0] reg_addr(input logic [5:0] base, input int i);
    reg_addr = 6'(base + 6'(i) * gpio_pkg::OFF_STEP);
  endfunction : reg_addr

  logic [5:0] data_q [6];
  logic [5:0] dir_q  [6];
  logic [5:0] plu_q  [6];
  logic [5:0] next_data [6];
  logic [5:0] next_dir  [6];
  logic [5:0] next_plu  [6];
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  gpio_pkg::rst_state_t state, next_state;
  logic [gpio_pkg::STAB_W-1:0] cnt, next_cnt;
  logic        next_cpu_run;
  logic        next_boot_area;
  logic [21:0] next_pin_out, next_pin_oe, next_pullup_en;
  logic        hold;
  logic        access;
  logic        commit;

  assign hold   = srst | ~reset_in_active_low;
  assign access = (read | write) & waitrequest;
  // Writes land at the edge the master sees waitrequest low
  assign commit = write & ~waitrequest & byteenable[0];

  // Register file and bus answer
  always_comb begin
    next_readdata    = readdata;
    next_waitrequest = 1'b1;
    for (int i = 0; i < gpio_pkg::NPORT; i++) begin
      next_data[i] = data_q[i];
      next_dir[i]  = dir_q[i];
      next_plu[i]  = plu_q[i];
    end
    if (access) begin
      next_waitrequest = 1'b0;
      next_readdata    = 32'h0;
    end
    for (int i = 0; i < gpio_pkg::NPORT; i++) begin
      if (address == reg_addr(gpio_pkg::OFF_DATA0, i)) begin
        if (commit) begin
          next_data[i] = writedata[5:0] & width_mask(W[i]);
        end
        if (access) begin
          next_readdata[5:0] = 6'(pin_in >> LSB[i]) & width_mask(W[i]);
        end
      end
      if (address == reg_addr(gpio_pkg::OFF_DIR0, i)) begin
        if (commit) begin
          next_dir[i] = writedata[5:0] & width_mask(W[i]);
        end
        if (access) begin
          next_readdata[5:0] = dir_q[i];
        end
      end
      if (address == reg_addr(gpio_pkg::OFF_PLU0, i)) begin
        if (commit) begin
          next_plu[i] = writedata[5:0] & width_mask(W[i]);
        end
        if (access) begin
          next_readdata[5:0] = plu_q[i];
        end
      end
    end
    if (access && address == gpio_pkg::OFF_STAT) begin
      next_readdata[gpio_pkg::STAT_BOOT_BIT]  = boot_area;
      next_readdata[gpio_pkg::STAT_READY_BIT] = cpu_run;
    end
  end

  always_ff @(posedge clk) begin
    if (hold) begin
      for (int i = 0; i < gpio_pkg::NPORT; i++) begin
        data_q[i] <= gpio_pkg::DATA_RST;
        dir_q[i]  <= gpio_pkg::DIR_RST;
        plu_q[i]  <= gpio_pkg::PLU_RST;
      end
      readdata    <= 32'h0;
      waitrequest <= 1'b1;
    end else begin
      for (int i = 0; i < gpio_pkg::NPORT; i++) begin
        data_q[i] <= next_data[i];
        dir_q[i]  <= next_dir[i];
        plu_q[i]  <= next_plu[i];
      end
      readdata    <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end

  // Reset release sequencer
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_cpu_run   = cpu_run;
    next_boot_area = boot_area;
    unique case (state)
      gpio_pkg::IN_RESET: begin
        next_state = gpio_pkg::STABILIZE;
        next_cnt   = '0;
      end
      gpio_pkg::STABILIZE: begin
        next_cnt = cnt + 1'b1;
        if (cnt == gpio_pkg::STAB_W'(gpio_pkg::STAB_CYC - 1)) begin
          next_state     = gpio_pkg::RUN;
          next_cpu_run   = 1'b1;
          next_boot_area = boot_area_select_in;
        end
      end
      gpio_pkg::RUN: begin
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (hold) begin
      state     <= gpio_pkg::IN_RESET;
      cnt       <= '0;
      cpu_run   <= 1'b0;
      boot_area <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      cpu_run   <= next_cpu_run;
      boot_area <= next_boot_area;
    end
  end

  // Pin drivers
  always_comb begin
    next_pin_out   = '0;
    next_pin_oe    = '0;
    next_pullup_en = '0;
    for (int i = 0; i < gpio_pkg::NPORT; i++) begin
      for (int b = 0; b < W[i]; b++) begin
        next_pin_out[LSB[i]+b]   = dir_q[i][b] & data_q[i][b];
        next_pin_oe[LSB[i]+b]    = dir_q[i][b];
        next_pullup_en[LSB[i]+b] = plu_q[i][b] & ~dir_q[i][b];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (hold) begin
      pin_out   <= '0;
      pin_oe    <= '0;
      pullup_en <= '0;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      pullup_en <= next_pullup_en;
    end
  end
endmodule : gpio_ports

// *** dv/gpio_checker.sv ***
`timescale 1ns/100ps
module gpio_checker (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  input wire logic        reset_in_active_low,
  input wire logic        cpu_run,
  input wire logic        boot_area,
  input wire logic [21:0] pin_out,
  input wire logic [21:0] pin_oe,
  input wire logic [21:0] pullup_en
);
  logic [11:0] n;
  logic        rst;
  assign rst = srst | !reset_in_active_low;
  // Cycles since release with the core held
  always_ff @(posedge clk) n <= rst ? 12'h000 : n + 12'(!cpu_run);
  default clocking @(posedge clk); endclocking
  a_reset_inputs: assert property (srst |=> pin_oe == 0) else $error("oe");
  a_reset_pullups: assert property (srst |=> pullup_en == 0) else $error("pu");
  a_pin_holds: assert property (!reset_in_active_low |=> !cpu_run && pin_oe == 0)
    else $error("pin");
  a_input_undriven: assert property (disable iff (rst) (pin_out & ~pin_oe) == 0)
    else $error("drv");
  a_pullup_input: assert property (disable iff (rst) (pullup_en & pin_oe) == 0)
    else $error("pu oe");
  a_one_wait: assert property (disable iff (rst) (read | write) && waitrequest |=> !waitrequest)
    else $error("wait");
  a_stab_time: assert property (disable iff (rst) $rose(cpu_run) |-> n == 12'(gpio_pkg::STAB_CYC + 1))
    else $error("stab");
  a_boot_kept: assert property (disable iff (rst) cpu_run |=> $stable(boot_area) && cpu_run)
    else $error("boot");
  c_write: cover property (write && !waitrequest);
  c_run: cover property ($rose(cpu_run));
  c_drive: cover property (pin_oe != 0);
endmodule : gpio_checker
bind gpio_ports gpio_checker i_chk (.clk, .srst, .read, .write, .waitrequest,
  .reset_in_active_low, .cpu_run, .boot_area, .pin_out, .pin_oe, .pullup_en);

// *** dv/board_model.sv ***
`timescale 1ns/100ps
module board_model (
  input  wire logic        clk,
  input  wire logic [21:0] pin_out,
  input  wire logic [21:0] pin_oe,
  input  wire logic [21:0] pullup_en,
  output logic      [21:0] pin_in
);
  logic [21:0] flt = 22'h0;
  // Undriven, unpulled pins wander
  always @(posedge clk) flt <= ~pin_in;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pullup_en) | (~pin_oe & ~pullup_en & flt);
endmodule : board_model

// *** dv/tb_gpio_ports.sv ***
`timescale 1ns/100ps
module tb_gpio_ports;
  logic        clk = 0, srst = 1, read = 0, write = 0, reset_in_active_low = 1;
  logic        boot_area_select_in = 1, waitrequest, cpu_run, boot_area;
  logic [5:0]  address = 6'h00;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic [21:0] pin_in, pin_out, pin_oe, pullup_en;
  int          n_mismatch = 0, tests_run = 0, cyc = 0;
  always #50 clk = ~clk;
  gpio_ports i_dut (.clk, .srst, .address, .read, .write, .writedata, .byteenable(4'h1),
    .readdata, .waitrequest, .reset_in_active_low, .boot_area_select_in, .cpu_run,
    .boot_area, .pin_in, .pin_out, .pin_oe, .pullup_en);
  board_model i_brd (.clk, .pin_out, .pin_oe, .pullup_en, .pin_in);
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  always @(posedge clk) if (++cyc == 20000) begin
    n_mismatch++;
    give_verdict();
  end
  task check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  task acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a; writedata <= d; write <= wr; read <= !wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata; write <= 0; read <= 0;
  endtask : acc
  function automatic logic [5:0] ra(input logic [5:0] base, input int i);
    ra = 6'(base + 6'(i) * gpio_pkg::OFF_STEP);
  endfunction : ra
  task t_ports;
    logic [21:0] m;
    int          s;
    for (int i = 0; i < 6; i++) begin
      s = i == 0 ? 0 : i == 1 ? 4 : 6 + 2 * i;
      m = {16'h0, i == 0 ? 6'h0f : (i == 1 || i == 5) ? 6'h3f : 6'h03} << s;
      acc(0, ra(gpio_pkg::OFF_DIR0, i), 0); check(rd, 0);
      acc(0, ra(gpio_pkg::OFF_PLU0, i), 0); check(rd, 0);
      acc(1, ra(gpio_pkg::OFF_DATA0, i), 32'hff);
      acc(1, ra(gpio_pkg::OFF_DIR0, i), 32'hff);
      acc(0, ra(gpio_pkg::OFF_DIR0, i), 0); check(rd, 32'(m >> s));
      repeat (2) @(posedge clk); check(pin_oe & m, m); check(pin_out & m, m);
      acc(0, ra(gpio_pkg::OFF_DATA0, i), 0); check(rd, 32'(m >> s));
      acc(1, ra(gpio_pkg::OFF_PLU0, i), 32'hff);
      acc(1, ra(gpio_pkg::OFF_DIR0, i), 0);
      repeat (2) @(posedge clk); check(pullup_en & m, m); check(pin_oe & m, 0);
    end
    acc(1, 6'h3e, 32'hff); acc(0, 6'h3e, 0); check(rd, 0);
  endtask : t_ports
  task t_boot(input logic b);
    int k;
    reset_in_active_low <= 0; boot_area_select_in <= b;
    repeat (2) @(posedge clk);
    #1 check(pin_oe | pullup_en, 0); check(cpu_run, 0);
    @(posedge clk) reset_in_active_low <= 1;
    k = 0;
    do begin @(posedge clk); #1 k++; end while (cpu_run !== 1'b1 && k < 1100);
    check(k, gpio_pkg::STAB_CYC + 1); check(boot_area, b);
    acc(0, 6'h3c, 0); check(rd, {30'h0, 1'b1, b});
    acc(0, gpio_pkg::OFF_DIR0, 0); check(rd, 0);
  endtask : t_boot
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    t_ports; t_boot(0); t_boot(1);
    give_verdict;
  end
endmodule : tb_gpio_ports
